// *** hdl/ckps_pkg.sv ***
// Constants, register map and helpers for the clock prescaler and speed select block.
// Assumes a 100 MHz system clock standing in for the oscillator, and an APB master.
package ckps_pkg;

    // Register indices; the APB byte address is four times the index
    localparam logic [7:0] IDX_RELOAD  = 8'h97;  // Prescaler reload value
    localparam logic [7:0] IDX_MAIN    = 8'h8f;  // Main clock speed control
    localparam logic [7:0] IDX_AUX     = 8'haf;  // Auxiliary clock speed control
    localparam logic [7:0] IDX_STATUS  = 8'h80;  // Applied mode and strap status

    // Reset values
    localparam logic [7:0] RELOAD_RST  = 8'hff;  // Fastest setting, prescaler bypassed
    localparam logic [6:0] MAIN_RST    = 7'h00;  // Standard mode, all peripherals slow
    localparam logic       AUX_RST     = 1'b0;

    // Main control field positions
    localparam int BIT_X2   = 0;
    localparam int BIT_T0   = 1;
    localparam int BIT_T1   = 2;
    localparam int BIT_T2   = 3;
    localparam int BIT_SI   = 4;
    localparam int BIT_PCA  = 5;
    localparam int BIT_WD   = 6;
    localparam int BIT_RSV  = 7;
    localparam int BIT_SPI  = 0;  // In the auxiliary register
    localparam int BIT_STRAP = 1; // In the status register

    // Peripheral strobe vector: main bits 1..6 land on 0..5, serial interface on 6
    localparam int NUM_PER  = 7;
    localparam int PER_SI   = BIT_SI - 1;
    localparam int PER_SPI  = 6;

    // Serial port modes the speed bit applies to
    localparam logic [1:0] SER_MODE_SYNC  = 2'h0;
    localparam logic [1:0] SER_MODE_FIXED = 2'h2;

    // Prescaled clock ticks per machine cycle
    localparam logic [3:0] CYC_STD  = 4'hc;
    localparam logic [3:0] CYC_FAST = 4'h6;

    // Prescaler arithmetic
    localparam logic [7:0] RELOAD_TOP  = 8'hff;  // Reload value that bypasses the divider
    localparam logic [1:0] STRAP_SETTLE = 2'h2;  // Cycles for the strap synchroniser

    // Source ticks per prescaled period, minus one
    function automatic logic [8:0] ckps_pre_term(input logic [7:0] reload);
        ckps_pre_term = {(RELOAD_TOP - reload), 1'b0} - 9'h001;
    endfunction

    // Oscillator cycles between two prescaled ticks
    function automatic logic [10:0] ckps_div_cycles(input logic [7:0] reload, input logic x2);
        logic [10:0] base;
        base = {3'h0, RELOAD_TOP - reload};
        if (reload == RELOAD_TOP) ckps_div_cycles = x2 ? 11'h001 : 11'h002;
        else ckps_div_cycles = x2 ? (base << 1) : (base << 2);
    endfunction

endpackage

// *** hdl/ckps_sync2.sv ***
// Two-flop synchroniser for levels arriving from pins.
// Assumes the input is a slow level; no pulse is guaranteed to pass.
module ckps_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Level in and out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    typedef struct packed {
        logic [W-1:0] stage1;  // Read only by stage2
        logic [W-1:0] stage2;
    } ckps_sync_state_t;

    ckps_sync_state_t s;
    ckps_sync_state_t next_s;

    // Shift the level along
    always_comb begin
        next_s        = s;
        next_s.stage1 = asyncIn;
        next_s.stage2 = s.stage1;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) s <= '0;
        else s <= next_s;
    end

    assign syncOut = s.stage2;

endmodule

// *** hdl/ckps_cycle_strobe.sv ***
// Machine cycle strobe: one pulse per 6 or 12 prescaled clock ticks.
// Assumes baseTick is a one-cycle enable from the prescaler on the same clock.
module ckps_cycle_strobe (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Timing inputs
    input  wire logic baseTick,
    input  wire logic fast,
    // Strobe out
    output logic      cycleStrobe
);

    typedef struct packed {
        logic [3:0] cnt;     // Ticks into the current machine cycle
        logic       strobe;  // One-cycle machine cycle pulse
    } ckps_cyc_state_t;

    ckps_cyc_state_t s;
    ckps_cyc_state_t next_s;
    logic [3:0]      period;

    // Count ticks; a speed change mid-cycle wraps at the next tick rather than overrun
    always_comb begin
        next_s        = s;
        next_s.strobe = 1'b0;
        period        = fast ? ckps_pkg::CYC_FAST : ckps_pkg::CYC_STD;
        if (baseTick) begin
            if (s.cnt >= period - 4'h1) begin
                next_s.cnt    = 4'h0;
                next_s.strobe = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 4'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) s <= '0;
        else s <= next_s;
    end

    assign cycleStrobe = s.strobe;

    // Helper: ticks between strobes, and whether speed held all along
    logic [4:0] tickGap;
    logic       steady;
    logic       primed;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickGap <= 5'h00;
            steady  <= 1'b0;
            primed  <= 1'b0;
        end else begin
            if (s.strobe) tickGap <= {4'h0, baseTick};
            else tickGap <= tickGap + {4'h0, baseTick};
            if (s.strobe) steady <= 1'b1;
            else if (fast != $past(fast)) steady <= 1'b0;
            if (s.strobe) primed <= 1'b1;
        end
    end

    // Strobe spacing matches the selected speed
    chk_cycle_spacing : assert property (@(posedge clk) disable iff (!rst_b)
        (s.strobe && steady && primed && fast == $past(fast))
        |-> tickGap == (fast ? 5'h06 : 5'h0c))
        else $error("machine cycle spacing wrong");

endmodule

// *** hdl/ckps_clock_ctrl.sv ***
// Clock prescaler and speed select: half-rate stage, 8-bit prescaler, machine cycle strobes.
// Assumes clk is the oscillator, the security byte bit is a pin, and APB runs on clk.
module ckps_clock_ctrl #(
    parameter int APB_ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Strap and serial port context
    input  wire logic                  hardwareSecurityByteX2,
    input  wire logic [1:0]            serialMode,
    // Clock enables out
    output logic                       cpuClkTick,
    output logic                       cpuDoubleSpeedActive,
    output logic                       cpuCycleStrobe,
    output logic [ckps_pkg::NUM_PER-1:0] periphCycleStrobe
);

    // Refuse address buses too narrow for the register map
    if (APB_ADDR_W < 10) begin : gen_bad_width
        $error("APB_ADDR_W must be at least 10");
    end

    typedef struct packed {
        logic        ready;      // APB answer
        logic [31:0] rdata;      // Read data
        logic        slvErr;     // Unmapped access
        logic [7:0]  reload;     // Prescaler reload value
        logic [6:0]  mainCtl;    // Main speed control, reserved bit not stored
        logic        spiSpeed;   // Serial interface speed bit
        logic        x2Active;   // Applied double speed mode
        logic        halfPhase;  // Divide-by-two stage
        logic [8:0]  preCnt;     // Prescaler source tick count
        logic        baseTick;   // Prescaled clock enable
        logic [1:0]  strapCnt;   // Strap settle count
        logic        strapDone;  // Strap captured
    } ckps_main_state_t;

    ckps_main_state_t s;
    ckps_main_state_t next_s;

    // Synchronised strap
    logic hsbSync;

    // Decode and combinational helpers
    logic                         mapped;
    logic [7:0]                   regIdx;
    logic                         wrEn;
    logic                         srcTick;
    logic [31:0]                  readMux;
    logic [ckps_pkg::NUM_PER-1:0] periphFast;
    logic                         serialModeOk;

    // Strap pin crosses from outside, so two flops first
    ckps_sync2 #(
        .W (1)
    ) u_strap_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn (hardwareSecurityByteX2),
        .syncOut (hsbSync)
    );

    // Address decode: word aligned, above the map reads as unmapped
    always_comb begin
        regIdx = paddr[9:2];
        mapped = (paddr[1:0] == 2'h0) && (paddr[APB_ADDR_W-1:10] == '0)
              && (regIdx == ckps_pkg::IDX_RELOAD || regIdx == ckps_pkg::IDX_MAIN
               || regIdx == ckps_pkg::IDX_AUX || regIdx == ckps_pkg::IDX_STATUS);
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (regIdx)
            ckps_pkg::IDX_RELOAD: readMux[7:0] = s.reload;
            ckps_pkg::IDX_MAIN:   readMux[6:0] = s.mainCtl;
            ckps_pkg::IDX_AUX:    readMux[ckps_pkg::BIT_SPI] = s.spiSpeed;
            ckps_pkg::IDX_STATUS: begin
                readMux[ckps_pkg::BIT_X2]    = s.x2Active;
                readMux[ckps_pkg::BIT_STRAP] = s.strapDone;
            end
            default:              readMux = 32'h0000_0000;
        endcase
    end

    // A write lands only at the edge that completes the access phase
    assign wrEn = psel && penable && pwrite && s.ready && mapped;

    // Half-rate rising edge is when the divide-by-two flop is about to rise
    assign srcTick = s.x2Active ? 1'b1 : !s.halfPhase;

    // Peripheral speed: fast only in double speed with its bit clear
    always_comb begin
        serialModeOk = (serialMode == ckps_pkg::SER_MODE_SYNC)
                    || (serialMode == ckps_pkg::SER_MODE_FIXED);
        for (int i = 0; i < ckps_pkg::NUM_PER - 1; i++) begin
            periphFast[i] = s.x2Active && !s.mainCtl[i + 1];
        end
        periphFast[ckps_pkg::PER_SI]  = s.x2Active && !s.mainCtl[ckps_pkg::BIT_SI]
                                      && serialModeOk;
        periphFast[ckps_pkg::PER_SPI] = s.x2Active && !s.spiSpeed;
    end

    // Next state
    always_comb begin
        next_s = s;

        // APB: answer one cycle into the access phase
        next_s.ready = psel && penable && !s.ready;
        if (psel && penable && !s.ready) begin
            next_s.rdata  = pwrite ? 32'h0000_0000 : readMux;
            next_s.slvErr = !mapped;
        end else begin
            next_s.slvErr = 1'b0;
        end

        // Register writes
        if (wrEn) begin
            case (regIdx)
                ckps_pkg::IDX_RELOAD: next_s.reload = pwdata[7:0];
                ckps_pkg::IDX_MAIN:   next_s.mainCtl = pwdata[6:0];
                ckps_pkg::IDX_AUX:    next_s.spiSpeed = pwdata[ckps_pkg::BIT_SPI];
                default:              next_s.mainCtl = s.mainCtl;
            endcase
        end

        // Strap capture after release; overrides an early software write
        if (!s.strapDone) begin
            if (s.strapCnt == ckps_pkg::STRAP_SETTLE) begin
                next_s.mainCtl[ckps_pkg::BIT_X2] = hsbSync;
                next_s.strapDone = 1'b1;
            end else begin
                next_s.strapCnt = s.strapCnt + 2'h1;
            end
        end

        // Divide-by-two stage free-runs so the rising edge is always known
        next_s.halfPhase = !s.halfPhase;

        // Mode change only at the half-rate rising edge, so no short pulse
        if (!s.halfPhase) begin
            next_s.x2Active = s.mainCtl[ckps_pkg::BIT_X2];
        end

        // Prescaler; wrap with >= so a larger reload never overruns
        next_s.baseTick = 1'b0;
        if (s.reload == ckps_pkg::RELOAD_TOP) begin
            next_s.preCnt   = 9'h000;
            next_s.baseTick = srcTick;
        end else if (srcTick) begin
            if (s.preCnt >= ckps_pkg::ckps_pre_term(s.reload)) begin
                next_s.preCnt   = 9'h000;
                next_s.baseTick = 1'b1;
            end else begin
                next_s.preCnt = s.preCnt + 9'h001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s          <= '0;
            s.reload   <= ckps_pkg::RELOAD_RST;
            s.mainCtl  <= ckps_pkg::MAIN_RST;
            s.spiSpeed <= ckps_pkg::AUX_RST;
        end else begin
            s <= next_s;
        end
    end

    // CPU machine cycle: 12 periods standard, 6 double speed
    ckps_cycle_strobe u_cpu_cycle (
        .clk         (clk),
        .rst_b       (rst_b),
        .baseTick    (s.baseTick),
        .fast        (s.x2Active),
        .cycleStrobe (cpuCycleStrobe)
    );

    // One machine cycle strobe per peripheral
    for (genvar g = 0; g < ckps_pkg::NUM_PER; g++) begin : gen_periph
        ckps_cycle_strobe u_per_cycle (
            .clk         (clk),
            .rst_b       (rst_b),
            .baseTick    (s.baseTick),
            .fast        (periphFast[g]),
            .cycleStrobe (periphCycleStrobe[g])
        );
    end

    // Outputs straight from flops
    assign pready               = s.ready;
    assign prdata               = s.rdata;
    assign pslverr              = s.slvErr;
    assign cpuClkTick           = s.baseTick;
    assign cpuDoubleSpeedActive = s.x2Active;

    // Helpers: cycles between ticks and whether settings held meanwhile
    logic [10:0] tickGap;
    logic        dirty;
    logic        primed;
    logic        reloadWritten;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickGap       <= 11'h000;
            dirty         <= 1'b1;
            primed        <= 1'b0;
            reloadWritten <= 1'b0;
        end else begin
            tickGap <= s.baseTick ? 11'h001 : tickGap + 11'h001;
            if (s.reload != next_s.reload || s.x2Active != next_s.x2Active) dirty <= 1'b1;
            else if (s.baseTick) dirty <= 1'b0;
            if (s.baseTick) primed <= 1'b1;
            if (wrEn && regIdx == ckps_pkg::IDX_RELOAD) reloadWritten <= 1'b1;
        end
    end

    // Named steps of an APB access
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        penable && pready;
    endsequence

    chk_reset_reload : assert property (@(posedge clk) disable iff (!rst_b)
        !reloadWritten |-> s.reload == ckps_pkg::RELOAD_RST)
        else $error("reload not all ones before first write");

    chk_reload_write : assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && regIdx == ckps_pkg::IDX_RELOAD) |=> s.reload == $past(pwdata[7:0]))
        else $error("reload write lost");

    chk_tick_period : assert property (@(posedge clk) disable iff (!rst_b)
        (s.baseTick && !dirty && primed)
        |-> tickGap == ckps_pkg::ckps_div_cycles(s.reload, s.x2Active))
        else $error("prescaled period wrong");

    chk_slowest_std : assert property (@(posedge clk) disable iff (!rst_b)
        (s.baseTick && !dirty && primed && s.reload == 8'h00 && !s.x2Active)
        |-> tickGap == 11'h3fc)
        else $error("slowest standard period not 1020");

    chk_fastest_x2 : assert property (@(posedge clk) disable iff (!rst_b)
        (s.reload == ckps_pkg::RELOAD_TOP && s.x2Active && $past(s.x2Active)
         && $past(s.reload) == ckps_pkg::RELOAD_TOP) |-> ##1 s.baseTick)
        else $error("bypassed double speed tick missing");

    chk_x2_half_edge : assert property (@(posedge clk) disable iff (!rst_b)
        (s.x2Active != $past(s.x2Active)) |-> $past(s.halfPhase) == 1'b0)
        else $error("mode changed off the half-rate edge");

    chk_strap_load : assert property (@(posedge clk) disable iff (!rst_b)
        $rose(s.strapDone) |-> s.mainCtl[ckps_pkg::BIT_X2] == $past(hsbSync))
        else $error("strap not loaded");

    chk_periph_gating : assert property (@(posedge clk) disable iff (!rst_b)
        !s.x2Active |-> periphFast == '0 ##1 (!s.x2Active || $rose(s.x2Active)))
        else $error("peripheral fast outside double speed");

    chk_serial_mode : assert property (@(posedge clk) disable iff (!rst_b)
        (serialMode != ckps_pkg::SER_MODE_SYNC && serialMode != ckps_pkg::SER_MODE_FIXED)
        |-> !periphFast[ckps_pkg::PER_SI])
        else $error("serial speed bit applied in wrong mode");

    chk_aux_write : assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && regIdx == ckps_pkg::IDX_AUX)
        |=> s.spiSpeed == $past(pwdata[0]) && s.mainCtl == $past(s.mainCtl))
        else $error("aux write wrong");

    chk_reserved_bit : assert property (@(posedge clk) disable iff (!rst_b)
        (psel && penable && !s.ready && !pwrite && regIdx == ckps_pkg::IDX_MAIN)
        |=> prdata[ckps_pkg::BIT_RSV] == 1'b0)
        else $error("reserved bit reads set");

    chk_apb_answer : assert property (@(posedge clk) disable iff (!rst_b)
        apb_setup ##1 (psel && penable) |-> ##1 apb_answer)
        else $error("APB answer late");

endmodule

// *** tb/ckps_periph_model.sv ***
// Far-side model: the CPU and peripherals that consume the clock enables.
// Assumes the strobes are one-cycle pulses on clk and the tick may stay high every cycle; it reports their spacing.
module ckps_periph_model (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    // Enables from the block
    input  wire logic                              cpuClkTick,
    input  wire logic                              cpuCycleStrobe,
    input  wire logic [ckps_pkg::NUM_PER-1:0]      periphCycleStrobe,
    // Measured spacing in clk cycles, and event counts
    output logic      [15:0]                       tickGap,
    output logic      [15:0]                       cpuGap,
    output logic      [ckps_pkg::NUM_PER-1:0][15:0] periphGap,
    output logic      [15:0]                       tickCount,
    output logic      [15:0]                       cpuCount
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0]                        tickAge;    // Cycles since last tick
    logic [15:0]                        cpuAge;     // Cycles since last machine cycle
    logic [ckps_pkg::NUM_PER-1:0][15:0] periphAge;  // Same, per peripheral

    // Age counters; a gap is latched when the next pulse lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickAge <= 16'h0001;
            cpuAge <= 16'h0001;
            periphAge <= '{default: 16'h0001};
            tickGap <= 16'h0000;
            cpuGap <= 16'h0000;
            periphGap <= '{default: 16'h0000};
            tickCount <= 16'h0000;
            cpuCount <= 16'h0000;
        end else begin
            // Constant-high tick reads as a gap of one
            tickAge <= cpuClkTick ? 16'h0001 : tickAge + 16'h0001;
            if (cpuClkTick) begin
                tickGap <= tickAge;
                tickCount <= tickCount + 16'h0001;
            end
            cpuAge <= cpuCycleStrobe ? 16'h0001 : cpuAge + 16'h0001;
            if (cpuCycleStrobe) begin
                cpuGap <= cpuAge;
                cpuCount <= cpuCount + 16'h0001;
            end
            for (int i = 0; i < ckps_pkg::NUM_PER; i++) begin
                periphAge[i] <= periphCycleStrobe[i] ? 16'h0001 : periphAge[i] + 16'h0001;
                if (periphCycleStrobe[i]) periphGap[i] <= periphAge[i];
            end
        end
    end
endmodule

// *** tb/tb_ckps_clock_ctrl.sv ***
// Self-checking bench for the clock prescaler and speed select block.
// Assumes an APB master on clk and the peripheral model measuring enable spacing.
module tb_ckps_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    // Byte addresses, four times the register index
    localparam logic [11:0] ADDR_RELOAD = {2'h0, ckps_pkg::IDX_RELOAD, 2'h0};
    localparam logic [11:0] ADDR_MAIN   = {2'h0, ckps_pkg::IDX_MAIN, 2'h0};
    localparam logic [11:0] ADDR_AUX    = {2'h0, ckps_pkg::IDX_AUX, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {2'h0, ckps_pkg::IDX_STATUS, 2'h0};

    logic        clk;           // Oscillator
    logic        rst_b;         // Async reset
    logic        psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic        strapDouble;   // Security byte strap pin
    logic [1:0]  serialMode;    // Serial port mode
    logic        cpuClkTick, cpuDoubleSpeedActive, cpuCycleStrobe;
    logic [ckps_pkg::NUM_PER-1:0]       periphCycleStrobe;
    logic [15:0] tickGap, cpuGap, tickCount, cpuCount;
    logic [ckps_pkg::NUM_PER-1:0][15:0] periphGap;
    int          nMismatch = 0;
    int          comparisons = 0;

    ckps_clock_ctrl #(.APB_ADDR_W(12)) ckps_clock_ctrl_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .hardwareSecurityByteX2(strapDouble), .serialMode(serialMode),
        .cpuClkTick(cpuClkTick), .cpuDoubleSpeedActive(cpuDoubleSpeedActive),
        .cpuCycleStrobe(cpuCycleStrobe), .periphCycleStrobe(periphCycleStrobe));

    ckps_periph_model ckps_periph_model_inst (
        .clk(clk), .rst_b(rst_b), .cpuClkTick(cpuClkTick), .cpuCycleStrobe(cpuCycleStrobe),
        .periphCycleStrobe(periphCycleStrobe), .tickGap(tickGap), .cpuGap(cpuGap),
        .periphGap(periphGap), .tickCount(tickCount), .cpuCount(cpuCount));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One compare, counted
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Look mid-cycle, so the value seen is the one the next rising edge samples
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1, "no APB answer");
        rd = prdata;
        err = pslverr;
        // Release only after the completing rising edge
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_wr(input logic [11:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, addr, wd, rd, err);
    endtask

    // Read and compare data and error flag
    task automatic apb_chk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        check(rd, exp, "read data");
        check({31'h0, err}, {31'h0, expErr}, "slave error");
    endtask

    // Wait for n fresh ticks or machine cycles, bounded
    task automatic settle(input logic useCpu, input int n);
        logic [15:0] start;
        int          k;
        start = useCpu ? cpuCount : tickCount;
        k = 0;
        while (((useCpu ? cpuCount : tickCount) - start) < 16'(n) && k < 40000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 40000) check(32'h0, 32'h1, "enable never came");
    endtask

    // Expected tick period in clk cycles
    function automatic logic [31:0] exp_period(input logic [7:0] r, input logic dbl);
        logic [31:0] span;
        span = {24'h0, 8'hff - r};
        if (r == 8'hff) exp_period = dbl ? 32'h1 : 32'h2;
        else exp_period = dbl ? (span << 1) : (span << 2);
    endfunction

    // Peripheral cases: main control, aux bit, serial mode
    logic [7:0] caseMain [8] = '{8'h01, 8'h7f, 8'h7e, 8'h01, 8'h01, 8'h01, 8'h55, 8'h2b};
    logic       caseAux  [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [1:0] caseSer  [8] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0};
    logic [7:0] reloads  [4] = '{8'hff, 8'h00, 8'hfe, 8'h80};

    // Main sequence
    initial begin
        logic        slow;
        logic        dbl;
        logic [31:0] expGap;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        strapDouble = 1'b0;
        serialMode = 2'h0;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        // Reset state
        apb_chk(ADDR_RELOAD, 32'hff, 1'b0);
        apb_chk(ADDR_MAIN, 32'h0, 1'b0);
        apb_chk(ADDR_AUX, 32'h0, 1'b0);
        apb_chk(12'h004, 32'h0, 1'b1);
        settle(1'b0, 3);
        check({16'h0, tickGap}, 32'h2, "reset tick period");
        // Every reload extreme in both modes
        for (int m = 0; m < 2; m++) begin
            apb_wr(ADDR_MAIN, {31'h0, m[0]});
            for (int i = 0; i < 4; i++) begin
                apb_wr(ADDR_RELOAD, {24'h0, reloads[i]});
                apb_chk(ADDR_RELOAD, {24'h0, reloads[i]}, 1'b0);
                settle(1'b0, 3);
                check({16'h0, tickGap}, exp_period(reloads[i], m[0]), "tick period");
            end
            apb_chk(ADDR_STATUS, {30'h1, m[0]}, 1'b0);
        end
        // Back to the fastest reload, so the gaps below are short and known
        apb_wr(ADDR_RELOAD, 32'hff);
        // Reserved bit changes nothing
        apb_wr(ADDR_MAIN, 32'h80);
        apb_chk(ADDR_MAIN, 32'h0, 1'b0);
        settle(1'b0, 3);
        check({16'h0, tickGap}, 32'h2, "reserved bit effect");
        // Peripheral speed bits against mode and serial mode
        for (int c = 0; c < 8; c++) begin
            apb_wr(ADDR_MAIN, {24'h0, caseMain[c]});
            apb_wr(ADDR_AUX, {31'h0, caseAux[c]});
            serialMode <= caseSer[c];
            settle(1'b1, 5);
            dbl = caseMain[c][0];
            check({16'h0, cpuGap}, dbl ? 32'h6 : 32'h18, "cpu cycle gap");
            for (int i = 0; i < ckps_pkg::NUM_PER; i++) begin
                slow = (i == ckps_pkg::PER_SPI) ? caseAux[c] : caseMain[c][i + 1];
                if (i == ckps_pkg::PER_SI && caseSer[c][0]) slow = 1'b1;
                expGap = !dbl ? 32'h18 : (slow ? 32'hc : 32'h6);
                check({16'h0, periphGap[i]}, expGap, "peripheral gap");
            end
        end
        // Second reset with the strap set
        strapDouble <= 1'b1;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        apb_chk(ADDR_MAIN, 32'h1, 1'b0);
        apb_chk(ADDR_STATUS, 32'h3, 1'b0);
        settle(1'b0, 3);
        check({16'h0, tickGap}, 32'h1, "strap tick period");
        complete_run();
    end

    // Watchdog on the whole run
    initial begin
        #500000;
        nMismatch++;
        $display("[ERR] %0t run timed out", $time);
        complete_run();
    end
endmodule
